//--- rtl/mos_pkg.sv
// Purpose: shared constants for the motor output stage
// Assumes: 100 MHz system clock
// Notes:   counts derive from the printed figures
package mos_pkg;

    // ****************************************
    // clock and switching rate
    // ****************************************
    localparam int CLK_HZ         = 100_000_000;
    localparam int PWM_FREQ_HZ    = 16_700;
    // longest period that keeps the rate at or above 16.7 kHz
    localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;

    // ****************************************
    // duty figures in tenths of a percent
    // ****************************************
    localparam int INV_MIN_PERMIL = 2;
    localparam int SM_MAX_PERMIL  = 996;
    localparam int PERMIL         = 1000;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int          CMD_W     = 16;
    localparam int          NAXIS     = 8;
    localparam int          NDOUT     = 8;
    localparam logic [15:0] CMD_RST   = 16'h0000;
    localparam logic [7:0]  DOUT_RST  = 8'h00;
    localparam logic [15:0] SIGN_FLIP = 16'h8000;
    localparam logic [15:0] MAG_MAX   = 16'h7FFF;

endpackage

//--- rtl/mos_pwm_if.sv
// Purpose: settings and wave between the stage and its pulse core
// Assumes: one clock domain
// Notes:   period of zero gives a steady wave, low if high is zero, else high
interface mos_pwm_if;
    logic [15:0] period;
    logic [15:0] high;
    logic        wave;
    logic        boundary;

    modport src  (output period, output high, input wave, input boundary);
    modport core (input period, input high, output wave, output boundary);
endinterface

//--- rtl/mos_pwm_core.sv
// Purpose: period counter producing a pulse wave
// Assumes: settings may change at any time
// Notes:   settings are taken only as a period ends
module mos_pwm_core
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // settings and wave
    mos_pwm_if.core   pif
);

    logic [15:0] cnt_ff;
    logic [15:0] per_ff;
    logic [15:0] high_ff;
    logic        wave_ff;
    logic [16:0] cnt_inc;
    logic        wrap;
    logic [15:0] nxt_cnt;

    assign cnt_inc      = {1'b0, cnt_ff} + 17'h00001;
    assign wrap         = cnt_inc >= {1'b0, per_ff};
    assign nxt_cnt      = wrap ? 16'h0000 : cnt_inc[15:0];
    assign pif.wave     = wave_ff;
    assign pif.boundary = wrap;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff  <= 16'h0000;
            per_ff  <= 16'h0000;
            high_ff <= 16'h0000;
            wave_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            wave_ff <= cnt_ff < high_ff; // [R3] [R4] [R5]
            if (wrap)
            begin
                per_ff  <= pif.period; // [R18]
                high_ff <= pif.high;   // [R18]
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_mid_period;
        !wrap;
    endsequence

    a_settings_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R18]
        s_mid_period |=> $stable(per_ff) && $stable(high_ff))
        else $error("pulse settings changed inside a period");

    a_wave_duty: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5]
        (cnt_ff >= high_ff) |=> !wave_ff)
        else $error("wave high past its high count");

endmodule

//--- rtl/mos_output_stage.sv
// Purpose: one axis output stage: pwm or step, sign, enable, error, outputs
// Assumes: all inputs synchronous to SYS_CLK_I; commands are one-cycle pulses
// Notes:   motor command is two's complement, full scale is 16'h7FFF / 16'h8000

// Operation
// [R1] servo pwm runs at a fixed 16.7 kHz switching rate
// [R2] pwm format is inverter or sign-magnitude, chosen by the select
// [R3] inverter duty runs 0.2% to 50% to 99.8% across the command
// [R4] sign-magnitude duty runs 0% to 99.6%, polarity on the sign output
// [R5] step mode emits step pulses of 50% duty on the shared output
// [R6] step pulses may be low-going or high-going
// [R7] after reset the step output is low with select fitted, else undriven
// [R8] sign output carries command polarity for servo, direction for steppers
// [R9] error output goes low when any axis error exceeds the limit
// [R10] amplifier enable goes low on abort and on off-on-error
// [R11] servo motor command output refreshes once per sample period
// [R12] motor off holds the command output at the offset level
// [R13] eight digital outputs, set-bit drives high, clear-bit drives low
// [R14] one port write loads every digital output bit at once
// [R15] slow serial needs data lines only; faster rates use handshake lines
// [R16] sign-magnitude select chooses format and is active for every stepper axis
// [R17] abort low stops motion at once and ends the running program
// [R18] new duty or step settings take effect only at a period boundary
module mos_output_stage
#(
    parameter int PERIOD_CYC = mos_pkg::PWM_PERIOD_CYC
)
(
    // clock and reset
    input  wire logic                         SYS_CLK_I,
    input  wire logic                         RESETN_I,
    // configuration
    input  wire logic                         SM_SELECT_I,
    input  wire logic                         STEP_MODE_I,
    input  wire logic                         STEP_POL_I,
    input  wire logic                         OFF_ON_ERR_I,
    input  wire logic [15:0]                  OFFSET_LEVEL_I,
    input  wire logic [15:0]                  ERR_LIMIT_I,
    // motion commands
    input  wire logic                         MOTOR_ON_I,
    input  wire logic                         MOTOR_OFF_I,
    input  wire logic                         SAMPLE_TICK_I,
    input  wire logic [15:0]                  MOTOR_CMD_I,
    input  wire logic [15:0]                  STEP_PERIOD_I,
    input  wire logic                         STEP_DIR_I,
    input  wire logic                         ABORT_N_I,
    input  wire logic [16*mos_pkg::NAXIS-1:0] POS_ERR_I,
    // digital output commands
    input  wire logic                         SET_BIT_I,
    input  wire logic                         CLR_BIT_I,
    input  wire logic [2:0]                   BIT_IDX_I,
    input  wire logic                         PORT_WR_I,
    input  wire logic [7:0]                   PORT_DATA_I,
    // serial handshake
    input  wire logic                         SER_FAST_I,
    input  wire logic                         SER_CTS_I,
    output logic                              SER_TX_OK_O,
    // drive outputs
    output logic [15:0]                       MOTOR_CMD_O,
    output logic                              PWM_STEP_O,
    output logic                              PWM_STEP_OE_O,
    output logic                              SIGN_DIR_O,
    output logic                              AMP_EN_O,
    output logic                              ERROR_N_O,
    output logic                              MOTOR_ON_O,
    output logic                              PROG_ABORT_O,
    output logic [7:0]                        DOUT_O
);

    // ****************************************
    // duty arithmetic
    // ****************************************
    localparam int INV_LO   = PERIOD_CYC * mos_pkg::INV_MIN_PERMIL / mos_pkg::PERMIL;
    localparam int INV_SPAN = PERIOD_CYC - 2 * INV_LO;
    localparam int SM_SPAN  = PERIOD_CYC * mos_pkg::SM_MAX_PERMIL / mos_pkg::PERMIL;
    localparam logic [15:0] PERIOD_W = 16'(PERIOD_CYC);

    function automatic logic [15:0] duty_high(input logic [15:0] cmd, input logic sm);
        logic [15:0] mag;
        logic [31:0] prod;
        mag  = cmd[15] ? 16'(~cmd + 16'h0001) : cmd;
        prod = 32'h0;
        if (mag > mos_pkg::MAG_MAX)
            mag = mos_pkg::MAG_MAX;
        if (sm)
            prod = 32'(mag) * 32'(SM_SPAN); // [R4]
        else
            prod = (32'(cmd ^ mos_pkg::SIGN_FLIP) * 32'(INV_SPAN)) >> 1; // [R3]
        return 16'((prod >> 15) + (sm ? 32'h0 : 32'(INV_LO)));
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic        motor_on_ff;
    logic [15:0] cmd_ff;
    logic [15:0] cmd_out_ff;
    logic        active_ff;
    logic        abort_seen_ff;
    logic        prog_abort_ff;
    logic        err_n_ff;
    logic        sign_ff;
    logic        pwm_ff;
    logic [7:0]  dout_ff;
    logic        sm_eff;
    logic        err_any;
    logic        err_stop;
    logic        abort;
    logic [15:0] cmd_eff;
    logic [7:0]  nxt_dout;
    logic [7:0]  bit_mask;
    logic        shaped;
    mos_pwm_if   pif ();

    assign sm_eff   = SM_SELECT_I | STEP_MODE_I; // [R16]
    assign abort    = !ABORT_N_I;
    assign err_stop = OFF_ON_ERR_I & !err_n_ff;
    assign cmd_eff  = motor_on_ff ? cmd_ff : OFFSET_LEVEL_I; // [R12]
    assign bit_mask = 8'h01 << BIT_IDX_I;

    always_comb
    begin
        err_any = 1'b0;
        for (int i = 0; i < mos_pkg::NAXIS; i++)
            if (POS_ERR_I[16*i +: 16] > ERR_LIMIT_I)
                err_any = 1'b1; // [R9]
    end

    assign nxt_dout = PORT_WR_I ? PORT_DATA_I // [R14]
                    : SET_BIT_I ? (dout_ff | bit_mask) // [R13]
                    : CLR_BIT_I ? (dout_ff & ~bit_mask) // [R13]
                    : dout_ff;

    // step uses the half period high; servo uses the fixed period
    assign pif.period = STEP_MODE_I ? (motor_on_ff ? STEP_PERIOD_I : 16'h0000) // [R5]
                                    : PERIOD_W; // [R1]
    assign pif.high   = STEP_MODE_I ? (pif.period >> 1) // [R5]
                                    : duty_high(cmd_out_ff, SM_SELECT_I); // [R2]
    assign shaped     = STEP_MODE_I ? (STEP_POL_I ? pif.wave : !pif.wave) : pif.wave; // [R6]

    mos_pwm_core u_core
    (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RESETN_I),
        .pif     (pif)
    );

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            motor_on_ff   <= 1'b0;
            cmd_ff        <= mos_pkg::CMD_RST;
            cmd_out_ff    <= mos_pkg::CMD_RST;
            active_ff     <= 1'b0;
            abort_seen_ff <= 1'b0;
            prog_abort_ff <= 1'b0;
            err_n_ff      <= 1'b1;
            sign_ff       <= 1'b0;
            pwm_ff        <= 1'b0;
            dout_ff       <= mos_pkg::DOUT_RST;
        end
        else
        begin
            if (abort || err_stop || MOTOR_OFF_I)
                motor_on_ff <= 1'b0; // [R17] [R10]
            else if (MOTOR_ON_I)
                motor_on_ff <= 1'b1;
            if (SAMPLE_TICK_I)
                cmd_ff <= MOTOR_CMD_I; // [R11]
            cmd_out_ff    <= cmd_eff; // [R12]
            if (MOTOR_ON_I && !abort)
                active_ff <= 1'b1;
            abort_seen_ff <= abort;
            prog_abort_ff <= abort & !abort_seen_ff; // [R17]
            err_n_ff      <= !err_any; // [R9]
            sign_ff       <= STEP_MODE_I ? STEP_DIR_I : cmd_out_ff[15]; // [R8]
            pwm_ff        <= active_ff ? shaped : 1'b0; // [R7]
            dout_ff       <= nxt_dout;
        end
    end

    assign MOTOR_CMD_O   = cmd_out_ff;
    assign PWM_STEP_O    = pwm_ff;
    assign PWM_STEP_OE_O = active_ff | sm_eff; // [R7]
    assign SIGN_DIR_O    = sign_ff;
    assign AMP_EN_O      = motor_on_ff & ABORT_N_I & !err_stop; // [R10]
    assign ERROR_N_O     = err_n_ff;
    assign MOTOR_ON_O    = motor_on_ff;
    assign PROG_ABORT_O  = prog_abort_ff;
    assign DOUT_O        = dout_ff;
    assign SER_TX_OK_O   = !SER_FAST_I | SER_CTS_I; // [R15]

    // ****************************************
    // switching rate watch
    // ****************************************
    // cycles since the last period end, and whether that period was loaded in servo mode
    logic [15:0] gap_ff;
    logic        srv_ff;

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            gap_ff <= 16'h0000;
            srv_ff <= 1'b0;
        end
        else if (pif.boundary)
        begin
            gap_ff <= 16'h0000;
            srv_ff <= !STEP_MODE_I;
        end
        else
            gap_ff <= gap_ff + 16'h0001;
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence s_abort_edge;
        ABORT_N_I ##1 !ABORT_N_I;
    endsequence

    a_abort_amp_off: assert property (!ABORT_N_I |-> !AMP_EN_O ##1 !motor_on_ff) // [R10]
        else $error("amplifier enabled during abort");
    a_abort_program: assert property (s_abort_edge |=> PROG_ABORT_O ##1 !PROG_ABORT_O) // [R17]
        else $error("program abort pulse missing");
    a_error_output: assert property (err_any |=> !ERROR_N_O) // [R9]
        else $error("error output not low on excess error");
    a_cmd_refresh: assert property (!SAMPLE_TICK_I |=> $stable(cmd_ff)) // [R11]
        else $error("command changed without a sample tick");
    a_offset_hold: assert property (!motor_on_ff |=> MOTOR_CMD_O == $past(OFFSET_LEVEL_I)) // [R12]
        else $error("motor off output not at offset level");
    a_set_bit: assert property (SET_BIT_I && !PORT_WR_I |=> DOUT_O[$past(BIT_IDX_I)]) // [R13]
        else $error("set bit did not drive high");
    a_clear_bit: assert property (CLR_BIT_I && !SET_BIT_I && !PORT_WR_I // [R13]
        |=> !DOUT_O[$past(BIT_IDX_I)])
        else $error("clear bit did not drive low");
    a_port_write: assert property (PORT_WR_I |=> DOUT_O == $past(PORT_DATA_I)) // [R14]
        else $error("port write not loaded");
    a_step_dir: assert property (STEP_MODE_I |=> SIGN_DIR_O == $past(STEP_DIR_I)) // [R8]
        else $error("direction output wrong");
    a_stepper_sm: assert property (STEP_MODE_I |-> PWM_STEP_OE_O) // [R16]
        else $error("stepper axis without select active");
    a_reset_float: assert property (!active_ff && !sm_eff |-> !PWM_STEP_OE_O && !PWM_STEP_O) // [R7]
        else $error("step output driven before use");
    a_ser_handshake: assert property (SER_FAST_I && !SER_CTS_I |-> !SER_TX_OK_O) // [R15]
        else $error("fast transmit without clear to send");
    a_servo_rate: assert property (pif.boundary && srv_ff |-> gap_ff == PERIOD_W - 16'h0001) // [R1]
        else $error("servo switching period wrong");

endmodule

//--- verif/mos_amp_model.sv
// Purpose: amplifier or step driver seen from the drive pins
// Assumes: one clock; the bench clears the high counter between windows
// Notes:   an undriven pin reads back as the inverse of its last level
module mos_amp_model
(
    // clock and control from the bench
    input  wire logic        clk_i,
    input  wire logic        clr_i,
    input  wire logic        hold_cts_i,
    // drive pins
    input  wire logic        wave_i,
    input  wire logic        oe_i,
    // answers
    output logic             cts_o,
    output logic [15:0]      hi_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_lvl = 1'b0;
    logic pin;
    // an undriven pin shows the inverse of its last driven level
    assign pin   = oe_i ? wave_i : ~pin_lvl;
    assign cts_o = ~hold_cts_i;
    always @(posedge clk_i)
    begin
        if (oe_i)
            pin_lvl <= wave_i;
        hi_cnt_o <= clr_i ? 16'h0000 : hi_cnt_o + {15'h0000, pin};
    end
endmodule

//--- verif/mos_output_stage_tb.sv
// Purpose: self-checking bench for the motor output stage
// Assumes: shortened pwm period of 1000 clocks
// Notes:   duty is measured over two whole periods in steady state
module mos_output_stage_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 1000;
    localparam int LO  = PER * 2 / 1000;
    localparam int P_CLR = 0, P_TICK = 1, P_ON = 2, P_OFF = 3;
    logic clk = 1'b0, rst_n = 1'b0, sm = 1'b1, stp = 1'b0, pol = 1'b1, ooe = 1'b0;
    logic on = 1'b0, off = 1'b0, tick = 1'b0, dir = 1'b0, abort_n = 1'b1;
    logic setb = 1'b0, clrb = 1'b0, pwr = 1'b0, fast = 1'b0, hold = 1'b0, clr = 1'b0;
    logic [15:0] ofs = 16'h0000, lim = 16'hFFFF, cmd = 16'h0000, sper = 16'h0000;
    logic [127:0] perr = '0;
    logic [2:0] idx = 3'h0;
    logic [7:0] pdat = 8'h00, dexp;
    logic [15:0] mcmd, hi;
    logic [31:0] seed = 32'h697A, r;
    logic cts, txok, wave, oe, sdir, amp, errn, mon, pab;
    logic [7:0] dout;
    int err_total = 0, comparisons = 0;
    always #5 clk = ~clk;

    mos_output_stage #(.PERIOD_CYC(PER)) uut (.SYS_CLK_I(clk), .RESETN_I(rst_n),
        .SM_SELECT_I(sm), .STEP_MODE_I(stp), .STEP_POL_I(pol), .OFF_ON_ERR_I(ooe),
        .OFFSET_LEVEL_I(ofs), .ERR_LIMIT_I(lim), .MOTOR_ON_I(on), .MOTOR_OFF_I(off),
        .SAMPLE_TICK_I(tick), .MOTOR_CMD_I(cmd), .STEP_PERIOD_I(sper), .STEP_DIR_I(dir),
        .ABORT_N_I(abort_n), .POS_ERR_I(perr), .SET_BIT_I(setb), .CLR_BIT_I(clrb),
        .BIT_IDX_I(idx), .PORT_WR_I(pwr), .PORT_DATA_I(pdat), .SER_FAST_I(fast),
        .SER_CTS_I(cts), .SER_TX_OK_O(txok), .MOTOR_CMD_O(mcmd), .PWM_STEP_O(wave),
        .PWM_STEP_OE_O(oe), .SIGN_DIR_O(sdir), .AMP_EN_O(amp), .ERROR_N_O(errn),
        .MOTOR_ON_O(mon), .PROG_ABORT_O(pab), .DOUT_O(dout));
    mos_amp_model amp_m (.clk_i(clk), .clr_i(clr), .hold_cts_i(hold), .wave_i(wave),
        .oe_i(oe), .cts_o(cts), .hi_cnt_o(hi));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] exp_hi(input logic [15:0] c, input logic s);
        logic [31:0] p;
        logic [15:0] m;
        m = c[15] ? -c : c;
        if (m > mos_pkg::MAG_MAX)
            m = mos_pkg::MAG_MAX;
        if (s)
            p = {16'h0000, m} * (PER * 996 / 1000) >> 15;
        else
            p = LO + (({16'h0000, c ^ mos_pkg::SIGN_FLIP} * (PER - 2 * LO)) >> 16);
        return p[15:0];
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(input int k);
        clr  = k == P_CLR;
        tick = k == P_TICK;
        on   = k == P_ON;
        off  = k == P_OFF;
        cyc(1);
        {clr, tick, on, off} = 4'h0;
    endtask
    task automatic duty(input int per, input logic [15:0] e);
        pulse(P_CLR);
        cyc(2 * per);
        chk("high time", hi, e << 1);
    endtask
    task automatic servo(input logic [15:0] c, input logic s);
        sm = s;
        cmd = c;
        pulse(P_TICK);
        cyc(PER + 10);
        chk("motor command", mcmd, c);
        chk("sign", {15'h0000, sdir}, {15'h0000, c[15]});
        duty(PER, exp_hi(c, s));
    endtask
    task automatic end_of_test;
        $display("counts: %0d compared, %0d bad", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        err_total++;
        end_of_test();
    end
    initial
    begin
        cyc(4);
        chk("oe fitted", {15'h0000, oe}, 16'h0001);
        chk("pin in reset", {15'h0000, wave}, 16'h0000);
        chk("error idle", {15'h0000, errn}, 16'h0001);
        sm = 1'b0;
        cyc(1);
        chk("oe unfitted", {15'h0000, oe}, 16'h0000);
        rst_n = 1'b1;
        $display("test reset done");
        pulse(P_ON);
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            servo((i % 4 == 0) ? 16'h8000 : (i % 4 == 1) ? 16'h0000 :
                  (i % 4 == 2) ? 16'h7FFF : r[15:0], i[2]);
        end
        $display("test servo duty done");
        stp = 1'b1;
        sm = 1'b0;
        sper = 16'h0028;
        for (int i = 0; i < 2; i++)
        begin
            pol = i[0];
            dir = ~i[0];
            // the servo period in flight must end before step settings load
            cyc(PER + 10);
            chk("step oe", {15'h0000, oe}, 16'h0001);
            chk("direction", {15'h0000, sdir}, {15'h0000, dir});
            duty(40, 16'h0014);
        end
        // with no steps the pin rests at the idle level of the chosen polarity
        pol = 1'b0;
        sper = 16'h0000;
        cyc(50);
        chk("low-going idle", {15'h0000, wave}, 16'h0001);
        pol = 1'b1;
        cyc(2);
        chk("high-going idle", {15'h0000, wave}, 16'h0000);
        stp = 1'b0;
        $display("test step done");
        r = rnd();
        lim = {1'b0, r[14:0]};
        perr[80 +: 16] = lim;
        cyc(2);
        chk("error at limit", {15'h0000, errn}, 16'h0001);
        perr[80 +: 16] = lim + 16'h0001;
        cyc(2);
        chk("error over", {15'h0000, errn}, 16'h0000);
        ooe = 1'b1;
        cyc(2);
        chk("amp off on err", {15'h0000, amp}, 16'h0000);
        perr = '0;
        ooe = 1'b0;
        ofs = r[31:16];
        pulse(P_ON);
        pulse(P_OFF);
        cyc(3);
        chk("offset hold", mcmd, ofs);
        pulse(P_ON);
        abort_n = 1'b0;
        cyc(1);
        chk("abort pulse", {15'h0000, pab}, 16'h0001);
        pulse(P_ON);
        chk("abort once", {15'h0000, pab}, 16'h0000);
        chk("amp on abort", {15'h0000, amp}, 16'h0000);
        chk("motor stopped", {15'h0000, mon}, 16'h0000);
        abort_n = 1'b1;
        $display("test error and abort done");
        dexp = 8'h00;
        for (int i = 0; i < 16; i++)
        begin
            r = rnd();
            idx = r[4:2];
            pdat = r[15:8];
            pwr = r[1:0] == 2'h0 || r[1:0] == 2'h3;
            setb = r[1:0] == 2'h1 || r[1:0] == 2'h3;
            clrb = r[1:0] == 2'h2;
            dexp = pwr ? pdat : setb ? dexp | (8'h01 << idx) : dexp & ~(8'h01 << idx);
            cyc(1);
            {pwr, setb, clrb} = 3'h0;
            chk("outputs", {8'h00, dout}, {8'h00, dexp});
        end
        for (int i = 0; i < 4; i++)
        begin
            {hold, fast} = i[1:0];
            cyc(1);
            chk("tx ok", {15'h0000, txok}, {15'h0000, ~fast | ~hold});
        end
        $display("test outputs and serial done");
        end_of_test();
    end
endmodule
